// ### hw/lsp_conv.sv
// dual-channel integration timer with double-buffered result registers
`timescale 1ns/10ps
module lsp_conv #(
  parameter int unsigned INTEG_CYC = lsp_pkg::CONV_CYC
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic ch0_pulse_in,
  input wire logic ch1_pulse_in,
  lsp_res_if.conv res
);
  import lsp_pkg::*;

  logic [CONV_W-1:0] cnt_q;
  logic [15:0] acc0_q, acc1_q, sh0_q, sh1_q;
  logic pend_q;
  logic end_ev;

  assign end_ev = (cnt_q == CONV_W'(INTEG_CYC - 1));

  function automatic logic [15:0] sat_inc(input logic [15:0] v, input logic p);
    sat_inc = (p && v != 16'hFFFF) ? v + 16'h0001 : v;
  endfunction

  // ===========================================================
  // integration window
  // free-running restart
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cnt_q <= '0;
    end else if (end_ev) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + CONV_W'(1);
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      acc0_q <= 16'h0000;
      acc1_q <= 16'h0000;
      sh0_q <= 16'h0000;
      sh1_q <= 16'h0000;
    end else if (end_ev) begin
      sh0_q <= acc0_q;
      sh1_q <= acc1_q;
      acc0_q <= 16'h0000;
      acc1_q <= 16'h0000;
    end else begin
      acc0_q <= sat_inc(acc0_q, ch0_pulse_in);
      acc1_q <= sat_inc(acc1_q, ch1_pulse_in);
    end
  end

  // ===========================================================
  // visible copy only moves while no bus transfer is open, so a
  // multi-byte read never mixes two conversions
  // deferred double buffer
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      pend_q <= 1'b0;
      res.ch0 <= 16'h0000;
      res.ch1 <= 16'h0000;
    end else begin
      if (pend_q && !res.hold) begin
        res.ch0 <= sh0_q;
        res.ch1 <= sh1_q;
      end
      if (end_ev) begin
        pend_q <= 1'b1;
      end else if (!res.hold) begin
        pend_q <= 1'b0;
      end
    end
  end

  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_conv_capture: assert property (
    end_ev |=> pend_q && sh0_q == $past(acc0_q) && sh1_q == $past(acc1_q))
    else $error("conversion result not captured");
  a_hold_stable: assert property (res.hold |=> $stable(res.ch0) && $stable(res.ch1))
    else $error("data changed during a bus transfer");
  a_auto_restart: assert property (end_ev |=> cnt_q == '0 ##1 cnt_q == CONV_W'(1))
    else $error("integration did not restart");
endmodule

// ### hw/lsp_pkg.sv
// shared constants and types of the light-sensor serial register port
package lsp_pkg;
  // ===========================================================
  // bus addresses and address-select pin encodings
  localparam logic [6:0] ADDR_GND = 7'h29;
  localparam logic [6:0] ADDR_FLT = 7'h39;
  localparam logic [6:0] ADDR_VDD = 7'h49;
  localparam logic [6:0] ADDR_ARA = 7'h0C;
  localparam logic [1:0] SEL_GND = 2'h0;
  localparam logic [1:0] SEL_FLT = 2'h1;
  // ===========================================================
  // command byte fields
  localparam int CMD_BIT = 7;
  localparam int CLR_BIT = 6;
  localparam int WORD_BIT = 5;
  localparam int BLK_BIT = 4;
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] CLR_MASK = 8'h40;
  localparam logic [7:0] BLK_RD_CMD = 8'h9B;
  localparam logic [7:0] BLK_RD_CNT = 8'h04;
  // ===========================================================
  // register indices and reset values
  localparam logic [3:0] REG_LAST_RW = 4'h6;
  localparam logic [3:0] REG_ID = 4'hA;
  localparam logic [3:0] REG_D0L = 4'hC;
  localparam logic [3:0] REG_D0H = 4'hD;
  localparam logic [3:0] REG_D1L = 4'hE;
  localparam logic [3:0] REG_D1H = 4'hF;
  localparam logic [7:0] REG_TIM_RST = 8'h02;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // ===========================================================
  // timing: 40 MHz system clock
  localparam int CLK_NS = 25;
  localparam int TO_MS = 25;
  localparam int TO_CYC = (TO_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int TO_W = 24;
  localparam int CONV_MS = 100;
  localparam int CONV_CYC = (CONV_MS * 1000000) / CLK_NS;
  localparam int CONV_W = 24;
  // ===========================================================
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_WR, ST_ACK, ST_RD, ST_RACK} lsp_state_t;
endpackage

// ### hw/lsp_res_if.sv
// result hand-over between the converter core and the serial port
`timescale 1ns/10ps
interface lsp_res_if;
  logic [15:0] ch0;
  logic [15:0] ch1;
  logic hold;
  modport conv (output ch0, output ch1, input hold);
  modport port (input ch0, input ch1, output hold);
endinterface

// ### hw/lsp_top.sv
// two-wire slave register port of a dual-channel light sensor
`timescale 1ns/10ps
module lsp_top #(
  parameter int unsigned TIMEOUT_CYC = lsp_pkg::TO_CYC,
  parameter int unsigned INTEG_CYC = lsp_pkg::CONV_CYC,
  parameter logic [7:0] ID_VAL = 8'h5A // arbitrary identification value
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_sel_in,
  input wire logic ch0_pulse_in,
  input wire logic ch1_pulse_in,
  output logic [7:0] ctrl_out,
  output logic [7:0] timing_out,
  output logic int_clear_out,
  output logic timeout_out,
  output logic [7:0] blk_len_out
);
  import lsp_pkg::*;

  lsp_state_t st_q;
  logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
  logic [1:0] sel_s1_q, sel_s2_q;
  logic [3:0] bit_q, ptr_q;
  logic [7:0] sh_q, cmd_q, len_q, tx, rd_mux;
  logic [7:0] regs_q [0:6];
  logic rw_q, ara_q, first_q, skip_q, ins_q, sda_out_q, sda_oe_q, clr_q, to_q;
  logic [TO_W-1:0] to_cnt_q;
  logic [6:0] own_addr;
  logic scl_rise, scl_fall, start_ev, stop_ev, to_ev, ev_ok;
  logic byte_in, wr_strobe, cmd_ev, rd_load, hit_dev, hit_ara, auto_inc;

  lsp_res_if res ();

  lsp_conv #(.INTEG_CYC(INTEG_CYC)) u_conv (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .ch0_pulse_in(ch0_pulse_in),
    .ch1_pulse_in(ch1_pulse_in),
    .res(res)
  );

  // ===========================================================
  // pin synchronisers; the third stage only feeds edge detection
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= 3'h7;
      {sda_s1_q, sda_s2_q, sda_s3_q} <= 3'h7;
      sel_s1_q <= 2'h0;
      sel_s2_q <= 2'h0;
    end else begin
      {scl_s1_q, scl_s2_q, scl_s3_q} <= {scl_in, scl_s1_q, scl_s2_q};
      {sda_s1_q, sda_s2_q, sda_s3_q} <= {sda_in, sda_s1_q, sda_s2_q};
      sel_s1_q <= addr_sel_in;
      sel_s2_q <= sel_s1_q;
    end
  end

  always_comb begin
    if (sel_s2_q == SEL_GND) begin
      own_addr = ADDR_GND;
    end else if (sel_s2_q == SEL_FLT) begin
      own_addr = ADDR_FLT;
    end else begin
      own_addr = ADDR_VDD;
    end
  end

  assign scl_rise = scl_s2_q && !scl_s3_q;
  assign scl_fall = !scl_s2_q && scl_s3_q;
  assign start_ev = scl_s2_q && scl_s3_q && sda_s3_q && !sda_s2_q;
  assign stop_ev = scl_s2_q && scl_s3_q && !sda_s3_q && sda_s2_q;
  assign ev_ok = !(to_ev || start_ev || stop_ev);
  assign hit_dev = (sh_q[7:1] == own_addr);
  assign hit_ara = (sh_q == {ADDR_ARA, 1'b1});
  assign byte_in = ev_ok && scl_fall && bit_q == BYTE_BITS && (st_q == ST_ADDR || st_q == ST_WR);
  assign wr_strobe = byte_in && st_q == ST_WR;
  assign cmd_ev = wr_strobe && first_q && sh_q[CMD_BIT];
  assign rd_load = ev_ok && scl_fall && ((st_q == ST_ACK && rw_q) || st_q == ST_RACK);
  assign auto_inc = cmd_q[WORD_BIT] || cmd_q[BLK_BIT];
  assign res.hold = (st_q != ST_IDLE);

  // ===========================================================
  // read data source
  // register at stored pointer
  always_comb begin
    if (ptr_q <= REG_LAST_RW) begin
      rd_mux = regs_q[ptr_q[2:0]];
    end else if (ptr_q == REG_ID) begin
      rd_mux = ID_VAL;
    end else if (ptr_q == REG_D0L) begin
      rd_mux = res.ch0[7:0];
    end else if (ptr_q == REG_D0H) begin
      rd_mux = res.ch0[15:8];
    end else if (ptr_q == REG_D1L) begin
      rd_mux = res.ch1[7:0];
    end else if (ptr_q == REG_D1H) begin
      rd_mux = res.ch1[15:8];
    end else begin
      rd_mux = 8'h00;
    end
  end

  always_comb begin
    if (ara_q) begin
      tx = {own_addr, 1'b0};
    end else if (ins_q) begin
      tx = BLK_RD_CNT;
    end else begin
      tx = rd_mux;
    end
  end

  // ===========================================================
  // bus state machine
  // all transfer formats share one byte engine
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      st_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rw_q <= 1'b0;
      ara_q <= 1'b0;
      sda_out_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (to_ev || stop_ev) begin
      st_q <= ST_IDLE;
      sda_out_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else if (start_ev) begin
      st_q <= ST_ADDR;
      bit_q <= 4'h0;
      sda_out_q <= 1'b1;
      sda_oe_q <= 1'b0;
    end else begin
      case (st_q)
        ST_ADDR, ST_WR: begin
          if (scl_rise) begin
            sh_q <= {sh_q[6:0], sda_s2_q};
            bit_q <= bit_q + 4'h1;
          end else if (byte_in) begin
            if (st_q == ST_WR || hit_dev || hit_ara) begin
              st_q <= ST_ACK;
              sda_out_q <= 1'b0;
              sda_oe_q <= 1'b1;
              // direction bit taken from address byte
              if (st_q == ST_ADDR) begin
                rw_q <= sh_q[0];
                ara_q <= hit_ara;
              end
            end else begin
              st_q <= ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_q <= 4'h0;
            if (rw_q) begin
              st_q <= ST_RD;
              sda_out_q <= tx[7];
              sda_oe_q <= !tx[7];
              sh_q <= {tx[6:0], 1'b0};
            end else begin
              st_q <= ST_WR;
              sda_out_q <= 1'b1;
              sda_oe_q <= 1'b0;
            end
          end
        end
        ST_RD: begin
          if (scl_rise) begin
            bit_q <= bit_q + 4'h1;
          end else if (scl_fall) begin
            if (bit_q == BYTE_BITS) begin
              st_q <= ST_RACK;
              sda_out_q <= 1'b1;
              sda_oe_q <= 1'b0;
            end else begin
              sda_out_q <= sh_q[7];
              sda_oe_q <= !sh_q[7];
              sh_q <= {sh_q[6:0], 1'b0};
            end
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s2_q) begin
            st_q <= ST_IDLE;
          end else if (scl_fall) begin
            st_q <= ST_RD;
            bit_q <= 4'h0;
            sda_out_q <= tx[7];
            sda_oe_q <= !tx[7];
            sh_q <= {tx[6:0], 1'b0};
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ===========================================================
  // command, pointer and register file
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      cmd_q <= CMD_RST;
      ptr_q <= CMD_RST[3:0];
      first_q <= 1'b0;
      skip_q <= 1'b0;
      ins_q <= 1'b0;
      clr_q <= 1'b0;
      len_q <= 8'h00;
      blk_len_out <= 8'h00;
      regs_q <= '{default: 8'h00};
      regs_q[1] <= REG_TIM_RST;
    end else begin
      clr_q <= 1'b0;
      if (start_ev) begin
        first_q <= 1'b1;
        skip_q <= 1'b0;
        len_q <= 8'h00;
      end else if (stop_ev) begin
        ins_q <= 1'b0;
        blk_len_out <= len_q;
      end
      if (wr_strobe) begin
        first_q <= 1'b0;
        if (cmd_ev) begin
          ptr_q <= sh_q[3:0];
          cmd_q <= sh_q & ~CLR_MASK;
          clr_q <= sh_q[CLR_BIT];
          ins_q <= (sh_q == BLK_RD_CMD);
          skip_q <= sh_q[BLK_BIT];
        end else if (skip_q) begin
          skip_q <= 1'b0;
        end else begin
          if (ptr_q <= REG_LAST_RW) begin
            regs_q[ptr_q[2:0]] <= sh_q;
          end
          len_q <= len_q + 8'h01;
          if (auto_inc) begin
            ptr_q <= ptr_q + 4'h1;
          end
        end
      end else if (rd_load && !ara_q) begin
        if (ins_q) begin
          ins_q <= 1'b0;
          ptr_q <= REG_D0L;
        end else begin
          len_q <= len_q + 8'h01;
          if (auto_inc) begin
            ptr_q <= ptr_q + 4'h1;
          end
        end
      end
    end
  end

  // ===========================================================
  // line-low timeout; saturates so the bus stays released while held
  assign to_ev = (to_cnt_q == TO_W'(TIMEOUT_CYC - 1));
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      to_cnt_q <= '0;
      to_q <= 1'b0;
    end else begin
      to_q <= to_ev;
      if (scl_s2_q && sda_s2_q) begin
        to_cnt_q <= '0;
      end else if (!to_ev) begin
        to_cnt_q <= to_cnt_q + TO_W'(1);
      end
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe_out = sda_oe_q;
  assign ctrl_out = regs_q[0];
  assign timing_out = regs_q[1];
  assign int_clear_out = clr_q;
  assign timeout_out = to_q;

  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  a_own_addr: assert property (
    byte_in && st_q == ST_ADDR && hit_dev |=> st_q == ST_ACK && sda_oe_out)
    else $error("own address not acknowledged");
  a_ara_ack: assert property (
    byte_in && st_q == ST_ADDR && hit_ara |=> st_q == ST_ACK && ara_q)
    else $error("alert address not acknowledged");
  a_cmd_nodata: assert property (cmd_ev |=> len_q == $past(len_q))
    else $error("command byte counted as data");
  a_ptr_load: assert property (cmd_ev |=> ptr_q == $past(sh_q[3:0]))
    else $error("pointer not loaded from command");
  a_rd_data: assert property (
    rd_load && !ins_q && !ara_q |=> sda_out_q == $past(rd_mux[7]))
    else $error("read bit not from pointed register");
  a_cnt_skip: assert property (
    wr_strobe && !first_q && skip_q |=> len_q == $past(len_q) && !skip_q)
    else $error("block byte count not dropped");
  a_rd_nack: assert property (
    st_q == ST_RACK && scl_rise && sda_s2_q |=> st_q == ST_IDLE)
    else $error("nack did not end the read");
  a_rd_turn: assert property (
    ev_ok && st_q == ST_ACK && rw_q && scl_fall |=> st_q == ST_RD)
    else $error("no turn to transmitter");
  a_time_out: assert property (to_ev |=> st_q == ST_IDLE && timeout_out && !sda_oe_out)
    else $error("timeout did not release the bus");
  a_ptr_reset: assert property (
    @(posedge clk_in) disable iff (1'b0) !rstn_in |=> ptr_q == 4'h0 && cmd_q == 8'h00)
    else $error("command not zero after reset");
  a_clr_pulse: assert property (
    cmd_ev && sh_q[CLR_BIT] |=> int_clear_out ##1 !int_clear_out)
    else $error("clear pulse wrong");
  a_blk_insert: assert property (
    rd_load && ins_q && !ara_q |=> ptr_q == REG_D0L && sh_q == 8'h08)
    else $error("byte count not inserted");
  a_ptr_step: assert property (
    wr_strobe && !cmd_ev && !skip_q && auto_inc |=> ptr_q == $past(ptr_q) + 4'h1)
    else $error("pointer did not advance");
  a_ptr_stop: assert property (stop_ev |=> $stable(ptr_q))
    else $error("pointer changed at stop");
endmodule

// ### tb/lsp_bus_master.sv
// serial bus master model driving scl and the open-drain sda level
`timescale 1ns/10ps
module lsp_bus_master (
  input wire logic clk_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  // ===========================================================
  // line phases: 8 system clocks per scl period (200 ns)
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // sda moves 2 clocks after scl falls, so no false start or stop is seen
  task automatic bit_io(input logic b, output logic r);
    sda_out <= b;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    r = sda_in;
    scl_out <= 1'b0;
    tick(2);
  endtask
  // ===========================================================
  // framing
  // start or repeated start
  task automatic start();
    sda_out <= 1'b1;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
    scl_out <= 1'b0;
    tick(2);
  endtask
  task automatic stop();
    sda_out <= 1'b0;
    tick(2);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(8);
  endtask
  task automatic hold(input int n);
    tick(n);
  endtask
  // ===========================================================
  // bytes, msb first
  task automatic wr(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask
  // master receives, nack on the last byte
  task automatic rd(input logic last, output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule

// ### tb/sensor_smbus_register_port_tb_top.sv
// self-checking testbench of the light-sensor serial register port
`timescale 1ns/10ps
module sensor_smbus_register_port_tb_top;
  import lsp_pkg::*;
  // must stay above the longest low run of sda in a read of zero bytes (about 220 clocks)
  localparam int unsigned TO_SIM = 400;
  localparam int unsigned INTEG_SIM = 100;
  // arbitrary identification value
  localparam logic [7:0] ID_SIM = 8'hC3;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  logic [1:0] addr_sel_in = 2'h0;
  logic ch0_pulse_in = 1'b1;
  logic ch1_pulse_in = 1'b0;
  logic scl_m, sda_m, sda_line, sda_out, sda_oe_out, int_clear_out, timeout_out;
  logic [7:0] ctrl_out, timing_out, blk_len_out, rv;
  logic ack;
  logic [7:0] got[$];
  logic [1:0] sel_tab[3];
  logic [6:0] adr_tab[3];
  int err_count = 0;
  int tests_run = 0;
  int clr_seen = 0;
  // pull-up on sda: low when either side pulls
  assign sda_line = sda_m & ~(sda_oe_out & ~sda_out);
  always #12.5 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (int_clear_out === 1'b1) begin
      clr_seen++;
    end
  end
  lsp_bus_master mst (.clk_in(clk_in), .sda_in(sda_line), .scl_out(scl_m), .sda_out(sda_m));
  lsp_top #(.TIMEOUT_CYC(TO_SIM), .INTEG_CYC(INTEG_SIM), .ID_VAL(ID_SIM)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl_m), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .addr_sel_in(addr_sel_in),
    .ch0_pulse_in(ch0_pulse_in), .ch1_pulse_in(ch1_pulse_in), .ctrl_out(ctrl_out),
    .timing_out(timing_out), .int_clear_out(int_clear_out), .timeout_out(timeout_out),
    .blk_len_out(blk_len_out)
  );
  // ===========================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("counts: %0d compared, %0d mismatched", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic done(input string name);
    $display("test %s finished, %0d mismatches so far", name, err_count);
  endtask
  // ===========================================================
  // access tasks
  // direction bit after the address
  task automatic xfer_wr(input logic [6:0] a, input logic [7:0] b[$]);
    mst.start();
    mst.wr({a, 1'b0}, ack);
    check(ack, 1'b1);
    foreach (b[i]) begin
      mst.wr(b[i], ack);
      check(ack, 1'b1);
    end
    mst.stop();
  endtask
  task automatic xfer_rd(input logic [6:0] a, input bit cmd_en, input logic [7:0] cmd,
                         input int n);
    got.delete();
    mst.start();
    if (cmd_en) begin
      mst.wr({a, 1'b0}, ack);
      mst.wr(cmd, ack);
      mst.start();
    end
    mst.wr({a, 1'b1}, ack);
    check(ack, 1'b1);
    for (int i = 0; i < n; i++) begin
      mst.rd(i == n - 1, rv);
      got.push_back(rv);
    end
    mst.stop();
  endtask
  task automatic probe(input logic [6:0] a, input logic exp);
    mst.start();
    mst.wr({a, 1'b0}, ack);
    check(ack, exp);
    mst.stop();
  endtask
  // ===========================================================
  // watchdog
  initial begin
    repeat (60000) @(posedge clk_in);
    err_count++;
    results();
  end
  // ===========================================================
  // test sequence
  initial begin
    repeat (12) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    check(ctrl_out, 8'h00);
    check(timing_out, REG_TIM_RST);
    xfer_wr(ADDR_GND, '{8'h03});
    check(ctrl_out, 8'h03);
    done("reset");
    sel_tab = '{SEL_GND, SEL_FLT, 2'h2};
    adr_tab = '{ADDR_GND, ADDR_FLT, ADDR_VDD};
    for (int i = 0; i < 3; i++) begin
      addr_sel_in <= sel_tab[i];
      repeat (6) @(posedge clk_in);
      probe(adr_tab[i], 1'b1);
      probe(adr_tab[(i + 1) % 3], 1'b0);
      xfer_rd(ADDR_ARA, 1'b0, 8'h00, 1);
      check(got[0], {adr_tab[i], 1'b0});
    end
    addr_sel_in <= SEL_GND;
    repeat (6) @(posedge clk_in);
    done("address");
    xfer_wr(ADDR_GND, '{8'h81, 8'h12});
    check(timing_out, 8'h12);
    check(blk_len_out, 8'h01);
    xfer_rd(ADDR_GND, 1'b0, 8'h00, 1);
    check(got[0], 8'h12);
    xfer_rd(ADDR_GND, 1'b0, 8'h00, 1);
    check(got[0], 8'h12);
    done("byte");
    xfer_wr(ADDR_GND, '{8'hA0, 8'h01, 8'h34});
    check(ctrl_out, 8'h01);
    check(timing_out, 8'h34);
    check(blk_len_out, 8'h02);
    xfer_rd(ADDR_GND, 1'b1, 8'hA0, 2);
    check({got[0], got[1]}, 16'h0134);
    xfer_wr(ADDR_GND, '{8'h90, 8'h07, 8'h05, 8'h06});
    check(ctrl_out, 8'h05);
    check(timing_out, 8'h06);
    check(blk_len_out, 8'h02);
    xfer_wr(ADDR_GND, '{8'hA2, 8'h11, 8'h22, 8'h33});
    check(blk_len_out, 8'h03);
    xfer_rd(ADDR_GND, 1'b1, 8'hA2, 3);
    check({got[0], got[1], got[2]}, 24'h112233);
    done("word and block");
    clr_seen = 0;
    xfer_wr(ADDR_GND, '{8'hC1});
    check(clr_seen, 1);
    xfer_rd(ADDR_GND, 1'b0, 8'h00, 1);
    check(got[0], 8'h06);
    check(int_clear_out, 1'b0);
    xfer_wr(ADDR_GND, '{8'h87, 8'h55});
    xfer_rd(ADDR_GND, 1'b0, 8'h00, 1);
    check(got[0], 8'h00);
    xfer_rd(ADDR_GND, 1'b1, 8'h8A, 1);
    check(got[0], ID_SIM);
    done("command bits");
    xfer_rd(ADDR_GND, 1'b1, BLK_RD_CMD, 5);
    check(got[0], BLK_RD_CNT);
    check(got[1] inside {[8'h63:8'h64]}, 1'b1);
    check({got[2], got[3], got[4]}, 24'h000000);
    check(sda_oe_out, 1'b0);
    check(sda_out, 1'b1);
    ch0_pulse_in <= 1'b0;
    ch1_pulse_in <= 1'b1;
    repeat (3 * INTEG_SIM) @(posedge clk_in);
    xfer_rd(ADDR_GND, 1'b1, BLK_RD_CMD, 5);
    check({got[1], got[2], got[4]}, 24'h000000);
    check(got[3] inside {[8'h63:8'h64]}, 1'b1);
    done("conversion");
    mst.start();
    mst.hold(TO_SIM - 20);
    check(timeout_out, 1'b0);
    mst.hold(40);
    check(timeout_out, 1'b1);
    check(sda_oe_out, 1'b0);
    mst.stop();
    check(timeout_out, 1'b0);
    xfer_wr(ADDR_GND, '{8'h81, 8'h02});
    check(timing_out, 8'h02);
    done("timeout");
    results();
  end
endmodule
